// ---- smr_map.svh ----
`ifndef SMR_MAP_SVH
`define SMR_MAP_SVH
// Cycles from wake to the end of the recovery sequence
`define SMR_RECOV_CYCLES   8'h10
// Recovery counter reset value
`define SMR_RECOV_ZERO     8'h00
// Watchdog oscillator tick divider, terminal count
`define SMR_WDOG_DIV_LAST  8'h0F
`define SMR_WDOG_DIV_ZERO  8'h00
// Watchdog terminal count in oscillator ticks
`define SMR_WDOG_LIMIT     16'h0FFF
`define SMR_WDOG_ZERO      16'h0000
// Reset pin function encodings
`define SMR_PINFUNC_RESET  2'h0
`endif

// ---- smr_pkg.sv ----
`default_nettype none
package smr_pkg;
   // Power state of the core
   typedef enum logic [1:0] {
      SMR_RUN,
      SMR_STOP,
      SMR_RECOVER,
      SMR_HUNG
   } smr_state_t;

   // Watchdog controls handed to the counter
   typedef struct packed {
      logic enable;
      logic oscOn;
      logic refresh;
   } smr_wdog_ctl_t;
endpackage : smr_pkg
`default_nettype wire

// ---- smr_wdog.sv ----
`default_nettype none
`include "smr_map.svh"
module smr_wdog (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               reset,
   // Control
   input  wire smr_pkg::smr_wdog_ctl_t ctl,
   // Status
   output var  logic               timeout_q
);
   logic [7:0]  divCnt_q;
   logic        tick_q;
   logic [15:0] count_q;

   // Oscillator tick, one cycle wide, only while the oscillator runs
   always_ff @(posedge clk_sys) begin
      if (reset || !ctl.oscOn) begin
         divCnt_q <= `SMR_WDOG_DIV_ZERO;
         tick_q   <= 1'b0;
      end else if (divCnt_q == `SMR_WDOG_DIV_LAST) begin
         divCnt_q <= `SMR_WDOG_DIV_ZERO;
         tick_q   <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + 8'h01;
         tick_q   <= 1'b0;
      end
   end

   // Count ticks while enabled; refresh restarts the count
   always_ff @(posedge clk_sys) begin
      if (reset || !ctl.enable || ctl.refresh) begin
         count_q   <= `SMR_WDOG_ZERO;
         timeout_q <= 1'b0;
      end else if (tick_q && count_q == `SMR_WDOG_LIMIT) begin
         count_q   <= `SMR_WDOG_ZERO;
         timeout_q <= 1'b1;
      end else begin
         if (tick_q) begin
            count_q <= count_q + 16'h0001;
         end
         timeout_q <= 1'b0;
      end
   end
endmodule // smr_wdog
`default_nettype wire

// ---- smr_recovery.sv ----
`default_nettype none
`include "smr_map.svh"
// What this block does
// R1: An interrupt that wakes the core from stop has its pending request discarded.
// R2: The watchdog keeps its enable through recovery instead of being switched off.
// R3: With the always-on option set the watchdog stays enabled across recovery.
// R4: Software must switch the watchdog oscillator off itself after stop.
// R5: Software should switch the watchdog oscillator back on before the next stop.
// R6: After reset the dedicated reset pin is set to its reset function.
// R7: With the reset pin on another function, stop recovery does not complete.
// R8: Software must restore the reset pin function before commanding stop.
module smr_recovery (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Core requests, one-cycle pulses on clk_sys
   input  wire logic       stopReq,
   input  wire logic       irqAck,
   input  wire logic       watchdogEnableReq,
   input  wire logic       watchdogRefresh,
   input  wire logic       watchdogOscOffReq,
   input  wire logic       watchdogOscOnReq,
   input  wire logic       pinFuncWrite,
   input  wire logic [1:0] pinFuncData,
   // Option bit, level
   input  wire logic       watchdog_always_on_option,
   // Wake interrupt pin, asynchronous
   input  wire logic       wakeIrqPin,
   // Status
   output var  logic       stopMode_q,
   output var  logic       recoveryDone_q,
   output var  logic       recoveryFail_q,
   output var  logic       irqPending_q,
   output var  logic       watchdogEn_q,
   output var  logic       watchdogOscOn_q,
   output var  logic       watchdogTimeout_q,
   output var  logic       resetPinIsReset_q
);
   smr_pkg::smr_state_t    state_q;
   logic                   wakeSync1_q;
   logic                   wakeSync2_q;
   logic                   wakeLast_q;
   logic                   wakeEdge;
   logic                   recovLast;
   logic                   pinIsReset;
   logic [7:0]             recovCnt_q;
   logic [1:0]             pinFunc_q;
   logic                   wdogTimeout;
   smr_pkg::smr_wdog_ctl_t wdogCtl;

   // Two-flop synchroniser, then edge history from the second stage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wakeSync1_q <= 1'b0;
         wakeSync2_q <= 1'b0;
         wakeLast_q  <= 1'b0;
      end else begin
         wakeSync1_q <= wakeIrqPin;
         wakeSync2_q <= wakeSync1_q;
         wakeLast_q  <= wakeSync2_q;
      end
   end

   assign wakeEdge = wakeSync2_q && !wakeLast_q;

   // Decodes shared by the sequencer and the status flags
   assign recovLast  = (recovCnt_q == `SMR_RECOV_CYCLES - 8'h01);
   assign pinIsReset = (pinFunc_q == `SMR_PINFUNC_RESET);

   // Reset pin function, software may reassign it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pinFunc_q <= `SMR_PINFUNC_RESET; // R6
      end else if (pinFuncWrite) begin
         pinFunc_q <= pinFuncData;
      end
   end

   // Stop, recovery and hang sequencing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q    <= smr_pkg::SMR_RUN;
         recovCnt_q <= `SMR_RECOV_ZERO;
      end else begin
         case (state_q)
            smr_pkg::SMR_RUN: begin
               if (stopReq) begin
                  state_q <= smr_pkg::SMR_STOP;
               end
            end
            smr_pkg::SMR_STOP: begin
               if (wakeEdge) begin
                  recovCnt_q <= `SMR_RECOV_ZERO;
                  if (pinIsReset) begin
                     state_q <= smr_pkg::SMR_RECOVER;
                  end else begin
                     state_q <= smr_pkg::SMR_HUNG; // R7
                  end
               end
            end
            smr_pkg::SMR_RECOVER: begin
               if (recovLast) begin
                  state_q <= smr_pkg::SMR_RUN;
               end else begin
                  recovCnt_q <= recovCnt_q + 8'h01;
               end
            end
            smr_pkg::SMR_HUNG: begin
               state_q <= smr_pkg::SMR_HUNG; // R7
            end
            default: begin
               state_q <= smr_pkg::SMR_RUN;
            end
         endcase
      end
   end

   // Stop status: high in stop and hung, low while recovering
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stopMode_q <= 1'b0;
      end else if (state_q == smr_pkg::SMR_RUN) begin
         stopMode_q <= stopReq;
      end else begin
         stopMode_q <= (state_q != smr_pkg::SMR_RECOVER);
      end
   end

   // One-cycle pulse in the cycle after the last recovery cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         recoveryDone_q <= 1'b0;
      end else begin
         recoveryDone_q <= (state_q == smr_pkg::SMR_RECOVER) && recovLast;
      end
   end

   // Failure flag: set by a wake with the pin reassigned, held until reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         recoveryFail_q <= 1'b0;
      end else if (state_q == smr_pkg::SMR_HUNG) begin
         recoveryFail_q <= 1'b1; // R7
      end else if ((state_q == smr_pkg::SMR_STOP) && wakeEdge && !pinIsReset) begin
         recoveryFail_q <= 1'b1; // R7
      end else begin
         recoveryFail_q <= 1'b0;
      end
   end

   // Pin function status
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         resetPinIsReset_q <= 1'b1; // R6
      end else begin
         resetPinIsReset_q <= pinIsReset;
      end
   end

   // Pending interrupt: edges in run set and win over ack; edges in stop, recovery and hang are discarded
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irqPending_q <= 1'b0;
      end else if (state_q == smr_pkg::SMR_STOP) begin
         irqPending_q <= 1'b0; // R1
      end else if (state_q == smr_pkg::SMR_RECOVER) begin
         irqPending_q <= 1'b0; // R1
      end else if (wakeEdge && state_q == smr_pkg::SMR_RUN) begin
         irqPending_q <= 1'b1;
      end else if (irqAck) begin
         irqPending_q <= 1'b0;
      end
   end

   // Watchdog enable survives recovery; option forces it on
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         watchdogEn_q <= 1'b0;
      end else if (watchdog_always_on_option) begin
         watchdogEn_q <= 1'b1; // R3
      end else if (watchdogEnableReq) begin
         watchdogEn_q <= 1'b1;
      end else begin
         watchdogEn_q <= watchdogEn_q; // R2
      end
   end

   // Oscillator control is left to software around stop
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         watchdogOscOn_q <= 1'b1;
      end else if (watchdogOscOnReq) begin
         watchdogOscOn_q <= 1'b1; // R5
      end else if (watchdogOscOffReq) begin
         watchdogOscOn_q <= 1'b0; // R4
      end
   end

   assign wdogCtl.enable  = watchdogEn_q;
   assign wdogCtl.oscOn   = watchdogOscOn_q;
   assign wdogCtl.refresh = watchdogRefresh;

   smr_wdog uWdog (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .ctl       (wdogCtl),
      .timeout_q (wdogTimeout)
   );

   // Registered timeout output
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         watchdogTimeout_q <= 1'b0;
      end else begin
         watchdogTimeout_q <= wdogTimeout;
      end
   end
endmodule // smr_recovery
`default_nettype wire

// ---- smr_recovery_assertions.sv ----
`default_nettype none
module smr_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Requests
   input wire logic stopReq,
   input wire logic watchdogOscOffReq,
   input wire logic watchdogOscOnReq,
   input wire logic watchdog_always_on_option,
   // Status
   input wire logic stopMode_q,
   input wire logic recoveryDone_q,
   input wire logic recoveryFail_q,
   input wire logic irqPending_q,
   input wire logic watchdogEn_q,
   input wire logic watchdogOscOn_q,
   input wire logic resetPinIsReset_q,
   input wire logic watchdogTimeout_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Protocol checks on the status outputs
   a_wake_not_pended: assert property ($rose(recoveryDone_q) |-> !irqPending_q)
      else $error("wake interrupt still pending after recovery");
   a_wdog_en_kept: assert property (watchdogEn_q |=> watchdogEn_q)
      else $error("watchdog enable dropped");
   a_option_forces_en: assert property (watchdog_always_on_option |=> watchdogEn_q)
      else $error("always-on option did not enable watchdog");
   a_pin_default_reset: assert property ($fell(reset) |-> resetPinIsReset_q)
      else $error("reset pin not on reset function after reset");
   a_fail_hangs: assert property (recoveryFail_q |=> recoveryFail_q && stopMode_q && !recoveryDone_q)
      else $error("hung recovery left stop");
   a_fail_cause: assert property ($rose(recoveryFail_q) |-> !resetPinIsReset_q)
      else $error("recovery failed with pin on reset function");
   a_stop_cause: assert property ($rose(stopMode_q) |-> $past(stopReq))
      else $error("stop entered without request");
   a_recov_length: assert property ($fell(stopMode_q) |-> ##[14:16] recoveryDone_q)
      else $error("recovery did not finish in time");
   a_osc_off: assert property (watchdogOscOffReq && !watchdogOscOnReq |=> !watchdogOscOn_q)
      else $error("watchdog oscillator did not stop");
   a_osc_off_quiet: assert property (!watchdogOscOn_q |-> ##3 !watchdogTimeout_q)
      else $error("watchdog expired with its oscillator stopped");
   // Main scenarios
   c_done: cover property (recoveryDone_q);
   c_fail: cover property (recoveryFail_q);
   c_pend: cover property (irqPending_q);
   c_timeout: cover property (watchdogTimeout_q);
endmodule // smr_chk
bind smr_recovery smr_chk i_smr_chk (.clk_sys, .reset, .stopReq, .watchdogOscOffReq,
   .watchdogOscOnReq, .watchdog_always_on_option, .stopMode_q, .recoveryDone_q,
   .recoveryFail_q, .irqPending_q, .watchdogEn_q, .watchdogOscOn_q, .resetPinIsReset_q,
   .watchdogTimeout_q);
`default_nettype wire

// ---- smr_tb.sv ----
`default_nettype none
`include "smr_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Design inputs
   logic       clk_sys = 1'b0, reset = 1'b1, stopReq = 1'b0, irqAck = 1'b0;
   logic       watchdogEnableReq = 1'b0, watchdogRefresh = 1'b0, pinFuncWrite = 1'b0;
   logic       watchdogOscOffReq = 1'b0, watchdogOscOnReq = 1'b0, wakeIrqPin = 1'b0;
   logic       watchdog_always_on_option = 1'b0;
   logic [1:0] pinFuncData = 2'h0;
   // Design outputs
   logic       stopMode_q, recoveryDone_q, recoveryFail_q, irqPending_q;
   logic       watchdogEn_q, watchdogOscOn_q, watchdogTimeout_q, resetPinIsReset_q;
   int         n_errors = 0, compares = 0, cycles = 0;
   bit         seen;
   // Watchdog expiry window after a refresh, in cycles, across all divider phases
   localparam int wdPer = int'(`SMR_WDOG_DIV_LAST) + 1;
   localparam int wdLo  = wdPer * int'(`SMR_WDOG_LIMIT) + 2;
   localparam int wdHi  = wdPer * (int'(`SMR_WDOG_LIMIT) + 1) + 1;
   smr_recovery i_smr_recovery (.clk_sys, .reset, .stopReq, .irqAck, .watchdogEnableReq,
      .watchdogRefresh, .watchdogOscOffReq, .watchdogOscOnReq, .pinFuncWrite, .pinFuncData,
      .watchdog_always_on_option, .wakeIrqPin, .stopMode_q, .recoveryDone_q, .recoveryFail_q,
      .irqPending_q, .watchdogEn_q, .watchdogOscOn_q, .watchdogTimeout_q, .resetPinIsReset_q);
   // Clock
   always #4 clk_sys = ~clk_sys;
   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 70000) begin
         n_errors++;
         close_out();
      end
   end
   task cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task do_reset;
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
   endtask
   // Wake pin high for two cycles, then back low; no stop request and no check
   task wake;
      wakeIrqPin = 1'b1;
      cyc(2);
      wakeIrqPin = 1'b0;
   endtask
   task stop_wake;
      stopReq = 1'b1;
      cyc(1);
      stopReq = 1'b0;
      `CHK(stopMode_q, 1'b1)
      wake();
      seen = 1'b0;
      repeat (30) begin
         @(negedge clk_sys);
         if (recoveryDone_q === 1'b1) seen = 1'b1;
      end
   endtask
   task t_reset;
      do_reset();
      `CHK(resetPinIsReset_q, 1'b1)
      `CHK(watchdogOscOn_q, 1'b1)
      `CHK(watchdogEn_q, 1'b0)
      $display("test reset done");
   endtask
   task t_irq_run;
      wake();
      cyc(4);
      `CHK(irqPending_q, 1'b1)
      irqAck = 1'b1;
      cyc(1);
      irqAck = 1'b0;
      cyc(1);
      `CHK(irqPending_q, 1'b0)
      $display("test irq done");
   endtask
   task t_recover;
      {watchdogEnableReq, watchdogRefresh, pinFuncWrite} = 3'h7;
      cyc(1);
      {watchdogEnableReq, watchdogRefresh, pinFuncWrite} = 3'h0;
      cyc(2);
      `CHK(resetPinIsReset_q, 1'b1)
      stopReq = 1'b1;
      cyc(1);
      stopReq = 1'b0;
      watchdogOscOffReq = 1'b1;
      cyc(1);
      watchdogOscOffReq = 1'b0;
      cyc(1);
      `CHK(watchdogOscOn_q, 1'b0)
      wake();
      repeat (30) @(negedge clk_sys);
      `CHK(stopMode_q, 1'b0)
      `CHK(irqPending_q, 1'b0)
      `CHK(watchdogEn_q, 1'b1)
      watchdogOscOnReq = 1'b1;
      cyc(1);
      watchdogOscOnReq = 1'b0;
      cyc(1);
      `CHK(watchdogOscOn_q, 1'b1)
      stop_wake();
      `CHK(seen, 1'b1)
      $display("test recovery done");
   endtask
   task t_wdog;
      int n;
      n = 0;
      watchdogRefresh = 1'b1;
      cyc(1);
      watchdogRefresh = 1'b0;
      while (watchdogTimeout_q !== 1'b1 && n < wdHi + 8) begin
         cyc(1);
         n++;
      end
      `CHK(n >= wdLo && n <= wdHi, 1'b1)
      cyc(1);
      `CHK(watchdogTimeout_q, 1'b0)
      $display("test watchdog done");
   endtask
   task t_option;
      do_reset();
      watchdog_always_on_option = 1'b1;
      cyc(2);
      `CHK(watchdogEn_q, 1'b1)
      stop_wake();
      `CHK(watchdogEn_q, 1'b1)
      $display("test option done");
   endtask
   task t_fail;
      pinFuncData = 2'h1;
      pinFuncWrite = 1'b1;
      cyc(1);
      pinFuncWrite = 1'b0;
      cyc(2);
      `CHK(resetPinIsReset_q, 1'b0)
      stop_wake();
      `CHK(seen, 1'b0)
      `CHK(recoveryFail_q, 1'b1)
      `CHK(stopMode_q, 1'b1)
      do_reset();
      `CHK(recoveryFail_q, 1'b0)
      `CHK(resetPinIsReset_q, 1'b1)
      $display("test fail done");
   endtask
   task close_out;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      @(negedge clk_sys);
      t_reset();
      t_irq_run();
      t_recover();
      t_wdog();
      t_option();
      t_fail();
      close_out();
   end
endmodule // tb
`default_nettype wire
